/* File: core/tra_core.v */
// Temperature result store, limit comparison and alert outputs with AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "tra_defines.vh"
module tra_core (
   input  wire        ref_clk_i,
   input  wire        rst_i,
   input  wire        conv_done_i,
   input  wire [13:0] conv_code_i,
   input  wire [15:0] nv_hi1_i,
   input  wire [15:0] nv_lo1_i,
   input  wire [15:0] nv_hi2_i,
   input  wire [15:0] nv_lo2_i,
   input  wire        clear_one_i,
   input  wire        clear_two_i,
   input  wire        limit_one_i,
   input  wire        limit_two_i,
   output wire        limit_out_one_o,
   output wire        limit_out_one_oe_o,
   output wire        limit_out_two_o,
   output wire        limit_out_two_oe_o,
   input  wire [5:0]  s_axi_awaddr,
   input  wire [2:0]  s_axi_awprot,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [5:0]  s_axi_araddr,
   input  wire [2:0]  s_axi_arprot,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   // Limit-defaults capture state
   localparam LD_LOAD = 1'b0;
   localparam LD_RUN  = 1'b1;

   reg         ld_state;
   reg  [15:0] result;
   reg  [15:0] config_reg;
   reg  [15:0] hi_lim [0:1];
   reg  [15:0] lo_lim [0:1];
   reg  [1:0]  over_limit_flag;
   reg  [1:0]  under_limit_flag;
   reg  [1:0]  alert_act;
   reg  [1:0]  clr_meta;
   reg  [1:0]  clr_sync;
   reg  [1:0]  clr_prev;
   reg  [5:0]  aw_addr;
   reg         aw_full;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg         w_full;
   wire [1:0]  mode_sel;
   wire [1:0]  polarity;
   wire [1:0]  clr_pulse;
   wire        cfg_read;
   wire        do_write;
   wire [15:0] new_word;
   wire [15:0] cfg_view;

   // Merge byte lanes of a write into a 16-bit register
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge16 = old;
         if (strb[0]) begin
            merge16[7:0] = data[7:0];
         end
         if (strb[1]) begin
            merge16[15:8] = data[15:8];
         end
      end
   endfunction

   // True when the address is one of the four limit registers
   function is_limit;
      input [5:0] a;
      begin
         is_limit = (a == `TRA_HI1_OFS) || (a == `TRA_LO1_OFS) ||
                    (a == `TRA_HI2_OFS) || (a == `TRA_LO2_OFS);
      end
   endfunction

   assign mode_sel = {config_reg[`TRA_CFG_MODE2], config_reg[`TRA_CFG_MODE1]};
   assign polarity = {config_reg[`TRA_CFG_CHANNEL_TWO_POLARITY], config_reg[`TRA_CFG_CHANNEL_ONE_POLARITY]};
   assign clr_pulse = clr_sync & ~clr_prev;

   assign new_word = {conv_code_i, {`TRA_PAD_W{1'b0}}};

   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready  = !w_full && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_full && w_full && !s_axi_bvalid;
   assign cfg_read = s_axi_arvalid && !s_axi_rvalid &&
                     (s_axi_araddr == `TRA_CONFIG_OFS);

   // under flag reads zero in therm mode
   assign cfg_view = {4'h0, over_limit_flag[0], under_limit_flag[0] & ~mode_sel[0],
                      over_limit_flag[1], under_limit_flag[1] & ~mode_sel[1],
                      config_reg[7:0]};

   // Alert clear inputs come from pins, two stages first
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clr_meta <= 2'h0;
         clr_sync <= 2'h0;
         clr_prev <= 2'h0;
      end else begin
         clr_meta <= {clear_two_i, clear_one_i};
         clr_sync <= clr_meta;
         clr_prev <= clr_sync;
      end
   end

   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         result <= 16'h0000;
      end else if (conv_done_i) begin
         result <= new_word;
      end
   end

   // AXI write channel capture, either order
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_full     <= 1'b0;
         w_full      <= 1'b0;
         aw_addr     <= 6'h00;
         w_data      <= 32'h0000_0000;
         w_strb      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TRA_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (is_limit(aw_addr) || aw_addr == `TRA_CONFIG_OFS ||
                aw_addr == `TRA_CMD_OFS || aw_addr == `TRA_RESULT_OFS) begin
               s_axi_bresp <= `TRA_RESP_OKAY;
            end else begin
               s_axi_bresp <= `TRA_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // defaults captured after reset release, writes override
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ld_state   <= LD_LOAD;
         config_reg <= `TRA_CFG_RST;
         hi_lim[0]  <= `TRA_DEF_HI;
         lo_lim[0]  <= `TRA_DEF_LO;
         hi_lim[1]  <= `TRA_DEF_HI;
         lo_lim[1]  <= `TRA_DEF_LO;
      end else begin
         case (ld_state)
            LD_LOAD: begin
               hi_lim[0] <= nv_hi1_i;
               lo_lim[0] <= nv_lo1_i;
               hi_lim[1] <= nv_hi2_i;
               lo_lim[1] <= nv_lo2_i;
               ld_state  <= LD_RUN;
            end
            LD_RUN: begin
               if (do_write) begin
                  case (aw_addr)
                     `TRA_CONFIG_OFS: config_reg[7:0] <= w_strb[0] ? w_data[7:0]
                                                                  : config_reg[7:0];
                     `TRA_HI1_OFS: hi_lim[0] <= merge16(hi_lim[0], w_data, w_strb);
                     `TRA_LO1_OFS: lo_lim[0] <= merge16(lo_lim[0], w_data, w_strb);
                     `TRA_HI2_OFS: hi_lim[1] <= merge16(hi_lim[1], w_data, w_strb);
                     `TRA_LO2_OFS: lo_lim[1] <= merge16(lo_lim[1], w_data, w_strb);
                     default: ;
                  endcase
               end
            end
            default: ld_state <= LD_LOAD;
         endcase
      end
   end

   // Per-channel flags and alert state
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         wire above;
         wire below;
         wire sw_clr;
         assign above = $signed(new_word) > $signed(hi_lim[ch]);
         assign below = $signed(new_word) < $signed(lo_lim[ch]);
         // clear by command pin, command write or config read
         assign sw_clr = clr_pulse[ch] || cfg_read ||
                         (do_write && aw_addr == `TRA_CMD_OFS && w_strb[0] &&
                          w_data[ch]);
         always @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
               over_limit_flag[ch]  <= 1'b0;
               under_limit_flag[ch] <= 1'b0;
               alert_act[ch]        <= 1'b0;
            end else if (mode_sel[ch]) begin
               if (conv_done_i && above) begin
                  over_limit_flag[ch]  <= 1'b1;
                  alert_act[ch]        <= 1'b1;
               end else if (conv_done_i && below) begin
                  over_limit_flag[ch]  <= 1'b0;
                  alert_act[ch]        <= 1'b0;
               end
               under_limit_flag[ch] <= 1'b0;
            end else begin
               // latch wins over a same-cycle clear
               if (conv_done_i && (above || below)) begin
                  over_limit_flag[ch]  <= over_limit_flag[ch] | above;
                  under_limit_flag[ch] <= under_limit_flag[ch] | below;
                  alert_act[ch]        <= 1'b1;
               end else if (sw_clr) begin
                  over_limit_flag[ch]  <= 1'b0;
                  under_limit_flag[ch] <= 1'b0;
                  alert_act[ch]        <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // pin level is active xor polarity; only low is driven
   assign limit_out_one_o    = 1'b0;
   assign limit_out_one_oe_o = ~(alert_act[0] ^ polarity[0]);
   assign limit_out_two_o    = 1'b0;
   assign limit_out_two_oe_o = ~(alert_act[1] ^ polarity[1]);

   // AXI read channel; result word carries both bytes
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `TRA_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `TRA_RESP_OKAY;
         case (s_axi_araddr)
            `TRA_RESULT_OFS: s_axi_rdata <= {16'h0000, result};
            `TRA_CONFIG_OFS: s_axi_rdata <= {16'h0000, cfg_view};
            `TRA_HI1_OFS:    s_axi_rdata <= {16'h0000, hi_lim[0]};
            `TRA_LO1_OFS:    s_axi_rdata <= {16'h0000, lo_lim[0]};
            `TRA_HI2_OFS:    s_axi_rdata <= {16'h0000, hi_lim[1]};
            `TRA_LO2_OFS:    s_axi_rdata <= {16'h0000, lo_lim[1]};
            `TRA_CMD_OFS:    s_axi_rdata <= 32'h0000_0000;
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `TRA_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Pin sense inputs unused; prot unused
   wire unused_ok;
   assign unused_ok = &{limit_one_i, limit_two_i, s_axi_awprot, s_axi_arprot, w_strb[3:2],
                        w_data[31:16], 1'b0};

endmodule
`default_nettype wire

/* File: core/tra_defines.vh */
// Constants for the temperature result and limit alert block
// Summary of operation
// - Every conversion result, 14 bits, replaces the stored temperature result.
// - Negative temperatures are twos complement, so the result is signed.
// - One code step equals 0.015625 degrees Celsius.
// - Result is presented 14-bit left-justified in a 16-bit word.
// - Each completed conversion is compared with both limits of each channel.
// - Two alert channels, each with own output and writable limit pair.
// - Per-channel polarity bit makes the alert output active high or low.
// - Each channel keeps an over-limit flag and an under-limit flag.
// - Per-channel mode bit: 0 latched alert mode (default), 1 therm mode.
// - Alert mode latches flag and output on crossing above high or below low.
// - Alert mode clears on alert-clear command or configuration register read.
// - Therm mode asserts above high limit, releases only below low limit.
// - In therm mode the under-limit flag reads zero.
// - Therm mode changes only at conversion end; reads and clears ignored.
// - Limits load nonvolatile defaults on the first clock after reset release; later writes override them.
// - While no alert is active, output level follows the polarity bit.
// - Alert outputs are open drain, pull low only, pullup gives high.
`ifndef TRA_DEFINES_VH
`define TRA_DEFINES_VH
`define TRA_RES_W        14
`define TRA_WORD_W       16
`define TRA_PAD_W        2
`define TRA_ADDR_W       6
`define TRA_RESULT_OFS   6'h00
`define TRA_CONFIG_OFS   6'h04
`define TRA_HI1_OFS      6'h08
`define TRA_LO1_OFS      6'h0C
`define TRA_HI2_OFS      6'h10
`define TRA_LO2_OFS      6'h14
`define TRA_CMD_OFS      6'h18
`define TRA_CFG_CHANNEL_ONE_POLARITY     7
`define TRA_CFG_MODE1    6
`define TRA_CFG_CHANNEL_TWO_POLARITY     3
`define TRA_CFG_MODE2    2
`define TRA_CFG_FH1      11
`define TRA_CFG_FL1      10
`define TRA_CFG_FH2      9
`define TRA_CFG_FL2      8
`define TRA_CFG_RST      16'h0000
`define TRA_CMD_CLR1     0
`define TRA_CMD_CLR2     1
`define TRA_RESP_OKAY    2'h0
`define TRA_RESP_SLVERR  2'h2
`define TRA_DEF_HI       16'h7FFC
`define TRA_DEF_LO       16'h8000
`endif

/* File: tb/tra_pin_model.sv */
// Pull-up model of the two open-drain alert wires
`timescale 1ns/1ns
`default_nettype none
module tra_pin_model (
   input  wire logic data_one_i,
   input  wire logic data_two_i,
   input  wire logic oe_one_i,
   input  wire logic oe_two_i,
   output var  logic pin_one_o,
   output var  logic pin_two_o
);
   always_comb begin
      pin_one_o = oe_one_i ? data_one_i : 1'b1;
      pin_two_o = oe_two_i ? data_two_i : 1'b1;
   end
endmodule
`default_nettype wire

/* File: tb/tra_core_assertions.sv */
// Concurrent checks on alert pins and register bus handshakes
`timescale 1ns/1ns
`default_nettype none
`include "tra_defines.vh"
module tra_core_assertions (
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic        conv_done_i,
   input wire logic        clear_one_i,
   input wire logic        limit_out_one_o,
   input wire logic        limit_out_one_oe_o,
   input wire logic        limit_out_two_o,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   chk_od_one_low: assert property (!limit_out_one_o)
      else $error("alert one data not low");
   chk_od_two_low: assert property (!limit_out_two_o)
      else $error("alert two data not low");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   chk_ar_gate: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read address ready wrong");
   chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `TRA_RESP_SLVERR
      |-> s_axi_rdata == 32'h0) else $error("error read data not zero");
   // Pin moves only after a conversion, clear, register read or write
   chk_alert_cause: assert property ($changed(limit_out_one_oe_o) |-> s_axi_bvalid
      || s_axi_rvalid || $past(s_axi_rvalid) || $past(conv_done_i) || $past(conv_done_i, 2)
      || $past(clear_one_i, 3) || $past(clear_one_i, 4) || $past(clear_one_i, 5))
      else $error("alert one moved without cause");
endmodule
bind tra_core tra_core_assertions i_chk (.*);
`default_nettype wire

/* File: tb/test_tra_core.sv */
// Self-checking bench for the result store and limit alert block
`timescale 1ns/1ns
`default_nettype none
`include "tra_defines.vh"
module test_tra_core;
   logic        ref_clk_i, rst_i, conv_done_i, clear_one_i, clear_two_i;
   logic [13:0] conv_code_i;
   logic [15:0] nv [4];
   logic [15:0] codes [4] = '{16'h3200, 16'hE700, 16'h7FFC, 16'h0000};
   logic [7:0]  pols [4] = '{8'h88, 8'h80, 8'h08, 8'h00};
   logic [5:0]  aw_a, ar_a;
   logic [31:0] w_d, rd_d;
   logic        awv, wv, arv, awr, wrr, bv, arr, rv;
   logic [1:0]  bresp, rresp;
   wire         p1, p2, o1, o2, e1, e2;
   logic [33:0] exp_q [$];
   int          failures, samples_checked;
   tra_core i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .conv_done_i(conv_done_i),
      .conv_code_i(conv_code_i), .nv_hi1_i(nv[0]), .nv_lo1_i(nv[1]), .nv_hi2_i(nv[2]),
      .nv_lo2_i(nv[3]), .clear_one_i(clear_one_i), .clear_two_i(clear_two_i),
      .limit_one_i(p1), .limit_two_i(p2), .limit_out_one_o(o1), .limit_out_one_oe_o(e1),
      .limit_out_two_o(o2), .limit_out_two_oe_o(e2), .s_axi_awaddr(aw_a),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(w_d),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(1'b1));
   tra_pin_model i_pins (.data_one_i(o1), .data_two_i(o2), .oe_one_i(e1), .oe_two_i(e2),
      .pin_one_o(p1), .pin_two_o(p2));
   task automatic check(input string nm, input logic [33:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      // A read still awaited at the end is a lost answer
      check("pending", 34'(exp_q.size()), 34'h0);
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d,
                     input logic [1:0] er = `TRA_RESP_OKAY);
      aw_a <= a;
      w_d <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (awr) awv <= 1'b0;
         if (wrr) wv <= 1'b0;
      end while (!bv);
      check("bresp", bresp, er);
   endtask
   task automatic rd(input logic [5:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      ar_a <= a;
      arv <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (arr) arv <= 1'b0;
      end while (!rv);
   endtask
   task automatic conv(input logic [15:0] w);
      conv_done_i <= 1'b1;
      conv_code_i <= w[15:2];
      @(posedge ref_clk_i);
      conv_done_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
   endtask
   task automatic pins(input logic a, b);
      @(posedge ref_clk_i);
      check("pin_one", p1, a);
      check("pin_two", p2, b);
   endtask
   task automatic clr(input logic two);
      clear_one_i <= !two;
      clear_two_i <= two;
      repeat (2) @(posedge ref_clk_i);
      clear_one_i <= 1'b0;
      clear_two_i <= 1'b0;
      repeat (5) @(posedge ref_clk_i);
   endtask
   // Results are judged as they come back, oldest note first
   always @(posedge ref_clk_i) begin
      if (rv && exp_q.size() > 0) begin
         check("rdata", {rresp, rd_d}, exp_q.pop_front());
      end
   end
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      failures++;
      finish_test();
   end
   initial begin
      void'($urandom(32'hDB586972));
      {rst_i, conv_done_i, clear_one_i, clear_two_i, awv, wv, arv} = 7'h40;
      {conv_code_i, aw_a, ar_a, w_d} = '0;
      foreach (nv[i]) nv[i] = 16'($urandom) & 16'hFFFC;
      codes[3] = 16'($urandom) & 16'hFFFC;
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      for (int i = 0; i < 4; i++) begin
         rd(6'(8 + 4 * i), {18'h0, nv[i]});
         wr(6'(8 + 4 * i), i[0] ? 32'h8000 : 32'h7FFC);
      end
      foreach (codes[i]) begin
         conv(codes[i]);
         rd(6'h00, {18'h0, codes[i]});
      end
      rd(6'h04, 34'h0);
      rd(6'h1C, {2'h2, 32'h0});
      wr(6'h1C, 32'h0, `TRA_RESP_SLVERR);
      foreach (pols[i]) begin
         wr(6'h04, {24'h0, pols[i]});
         pins(pols[i][7], pols[i][3]);
      end
      wr(6'h04, 32'h04);
      wr(6'h08, 32'h3200);
      wr(6'h0C, 32'hF000);
      conv(16'h3204);
      pins(1'b1, 1'b0);
      rd(6'h04, 34'h804);
      rd(6'h04, 34'h004);
      conv(16'h3200);
      pins(1'b0, 1'b0);
      conv(16'hE000);
      rd(6'h04, 34'h404);
      conv(16'hE000);
      pins(1'b1, 1'b0);
      clr(1'b0);
      pins(1'b0, 1'b0);
      conv(16'hE000);
      wr(6'h18, 32'h1);
      pins(1'b0, 1'b0);
      wr(6'h10, 32'h1000);
      wr(6'h14, 32'h0800);
      conv(16'h2000);
      rd(6'h04, 34'h204);
      rd(6'h04, 34'h204);
      clr(1'b1);
      wr(6'h18, 32'h2);
      conv(16'h0C00);
      pins(1'b0, 1'b1);
      conv(16'hF800);
      rd(6'h04, 34'h004);
      pins(1'b0, 1'b0);
      // Second reset in mid-run must reload the stored limit defaults
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      pins(1'b0, 1'b0);
      rd(6'h0C, {18'h0, nv[1]});
      rd(6'h04, 34'h0);
      rd(6'h00, 34'h0);
      @(posedge ref_clk_i);
      finish_test();
   end
endmodule
`default_nettype wire
